// ==== verif/host_model.sv ====
/* Host side: pull on the reset wire and chip select kicks.
   Assumes pins change at the falling clock edge. */
`timescale 1ns/1ps
module host_model #(parameter bit ACTIVE_HIGH = 1'b0) (
  input wire logic clk,
  input wire logic resetOe,
  input wire logic resetOut,
  input wire logic kick,
  input wire logic csIdle,
  output logic csN = 1'b1,
  output logic inReset
);
  logic [2:0] ph = 3'h0;
  // Released wire sits at the pull level, the inactive one
  assign inReset = (resetOe ? resetOut : !ACTIVE_HIGH) == ACTIVE_HIGH;
  always @(negedge clk) begin
    ph <= ph + 3'h1;
    csN <= kick ? ph[2] : csIdle;
  end
endmodule

// ==== verif/supervisor_reset_watchdog_assertions.sv ====
/* Port checker for the reset supervisor.
   Assumes one clock domain; attached by the bind at the foot. */
`timescale 1ns/1ps
module supervisor_checker #(
  parameter int RELEASE_CYC = 20,
  parameter bit ACTIVE_HIGH = 1'b0,
  parameter logic [7:0] TRIP_RAISED = 8'h01
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic supplyAboveTrip,
  input wire logic csN,
  input wire logic wpN,
  input wire logic lockEnableBit,
  input wire logic wdogEnable,
  input wire logic [31:0] wdogLimit,
  input wire logic resetOut,
  input wire logic resetOe,
  input wire logic [7:0] tripCode,
  input wire logic wdogFrozen
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [31:0] upReg, upNext, quietReg, quietNext;
  logic csReg;
  // Supply-good run length and chip-select quiet time
  always_comb begin
    upNext = supplyAboveTrip ? upReg + 32'h1 : 32'h0;
    quietNext = (resetOe || !wdogEnable || (csReg && !csN)) ? 32'h0
      : quietReg + 32'h1;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      upReg <= 32'h0;
      quietReg <= 32'h0;
      csReg <= 1'b1;
    end else begin
      upReg <= upNext;
      quietReg <= quietNext;
      csReg <= csN;
    end
  end
  pin_level_a: assert property (resetOut == ACTIVE_HIGH)
    else $error("reset drive level wrong");
  brownout_assert_a: assert property (
    !supplyAboveTrip |-> ##[0:5] resetOe)
    else $error("reset missing on low supply");
  release_delay_a: assert property (
    $fell(resetOe) |-> upReg >= RELEASE_CYC)
    else $error("reset released early");
  low_hold_a: assert property (resetOe && !supplyAboveTrip |=> resetOe)
    else $error("reset dropped while supply low");
  wdog_bound_a: assert property (!resetOe |->
    quietReg < 32'd8 || quietReg - 32'd8 <= wdogLimit)
    else $error("watchdog late");
  wdog_cause_a: assert property ($rose(resetOe) |->
    upReg < 32'd8 || quietReg + 32'd4 >= wdogLimit)
    else $error("reset without cause");
  freeze_on_a: assert property ((lockEnableBit && !wpN) [*6] |-> wdogFrozen)
    else $error("config not frozen");
  freeze_off_a: assert property (!(lockEnableBit && !wpN) [*6] |-> !wdogFrozen)
    else $error("config frozen wrongly");
  trip_code_a: assert property (tripCode == supervisor_pkg::TRIP_NATIVE
    || tripCode == TRIP_RAISED)
    else $error("bad threshold code");
  cover property ($fell(resetOe));
  cover property ($rose(resetOe) && supplyAboveTrip);
  cover property ($rose(wdogFrozen));
  cover property ($changed(tripCode));
endmodule
bind supervisor_reset_watchdog supervisor_checker #(
  .RELEASE_CYC(RELEASE_CYC), .ACTIVE_HIGH(ACTIVE_HIGH),
  .TRIP_RAISED(TRIP_RAISED)) mon (.clk, .arst_n, .supplyAboveTrip, .csN,
  .wpN, .lockEnableBit, .wdogEnable, .wdogLimit, .resetOut, .resetOe,
  .tripCode, .wdogFrozen);

// ==== verif/supervisor_reset_watchdog_test.sv ====
/* Self-checking bench for the reset supervisor.
   Assumes a short release count and the host model on chip select. */
`timescale 1ns/1ps
module supervisor_reset_watchdog_test;
  localparam int REL = 20;
  logic clk = 1'b0, arst_n = 1'b0, supplyAboveTrip = 1'b1, sck = 1'b0;
  logic sckProg = 1'b0, siProg = 1'b0, wpN = 1'b1, lockEnableBit = 1'b0;
  logic wdogEnable = 1'b0, kick = 1'b0, csIdle = 1'b1;
  logic resetOut, resetOe, wdogFrozen, csN, inReset;
  logic [31:0] wdogLimit = 32'hFFFFFFFF;
  logic [7:0] tripCode;
  int err_count = 0, n_tests = 0, cyc = 0, n, lim;
  initial forever #2 clk = !clk;
  supervisor_reset_watchdog #(.RELEASE_CYC(REL)) dut (.clk, .arst_n,
    .supplyAboveTrip, .supplyAbove1v(1'b1), .csN, .sck, .sckProg, .siProg,
    .wpN, .lockEnableBit, .wdogEnable, .wdogLimit, .resetOut, .resetOe,
    .tripCode, .wdogFrozen);
  host_model host (.clk, .resetOe, .resetOut, .kick, .csIdle, .csN,
    .inReset);
  function logic frozenExp(input logic l, input logic w);
    return l && !w;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task rng(input int v, input int lo, input int hi);
    n_tests++;
    if (v < lo || v > hi) begin
      err_count++;
      $display("BAD t=%0t count %0d not in %0d..%0d", $time, v, lo, hi);
    end
  endtask
  task waitOe(input logic lvl);
    n = 0;
    while (resetOe !== lvl && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task give_verdict;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      give_verdict;
    end
  end
  initial begin
    void'($urandom(32'h3FEA));
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    waitOe(1'b0);
    rng(n, REL, REL + 8);
    $display("power-up test done");
    repeat (3) begin
      supplyAboveTrip = 1'b0;
      repeat (5 + $urandom % 8) @(negedge clk);
      chk(resetOe, 1'b1);
      chk(inReset, 1'b1);
      supplyAboveTrip = 1'b1;
      waitOe(1'b0);
      rng(n, REL, REL + 8);
    end
    $display("brownout test done");
    lim = 40 + $urandom % 16;
    wdogLimit = lim;
    wdogEnable = 1'b1;
    kick = 1'b1;
    repeat (200) @(negedge clk);
    chk(resetOe, 1'b0);
    kick = 1'b0;
    waitOe(1'b1);
    rng(n, lim - 8, lim + 8);
    csIdle = 1'b0;
    waitOe(1'b0);
    waitOe(1'b1);
    rng(n, lim, lim + 8);
    $display("watchdog test done");
    lockEnableBit = 1'b1;
    wpN = 1'b0;
    repeat (8) @(negedge clk);
    chk(wdogFrozen, frozenExp(lockEnableBit, wpN));
    wpN = 1'b1;
    repeat (8) @(negedge clk);
    chk(wdogFrozen, frozenExp(lockEnableBit, wpN));
    waitOe(1'b1);
    wdogEnable = 1'b0;
    csIdle = 1'b1;
    waitOe(1'b0);
    $display("lock test done");
    sck = 1'b1;
    siProg = 1'b1;
    for (int i = 0; i < 2; i++) begin
      sckProg = (i == 0);
      repeat (4) @(negedge clk);
      csIdle = 1'b0;
      repeat (4) @(negedge clk);
      csIdle = 1'b1;
      repeat (12) @(negedge clk);
      lim = i ? supervisor_pkg::TRIP_NATIVE : 8'h01;
      chk(tripCode, lim);
    end
    $display("threshold test done");
    give_verdict;
  end
endmodule

// ==== verilog/supervisor_pkg.sv ====
/*
  Constants for the reset supervisor; its watchdog counter uses none of them.
  Assumes a single 250 MHz clock; supply comparisons arrive as flags.
*/
// Contract
// - The reset pin is open drain, active low or high by variant.
// - Reset holds while the supply is below trip and 200 ms after.
// - At power-up reset asserts near 1 V and holds 200 ms past trip.
// - On collapse reset stays asserted until the supply is below 1 V.
// - An enabled watchdog asserts reset if chip select stays static.
// - Each falling chip select edge restarts the watchdog count.
// - Write-lock pin plus lock_enable_bit freeze watchdog settings.
// - Select and lock high, programming level on clock and data,
//   then a chip select low-high pulse raises the stored threshold.
// - Same with serial clock high and programming level on data only
//   restores the native threshold.
// - After restore the threshold returns to its native value.
package supervisor_pkg;
  localparam int CLK_MHZ = 250;
  localparam int RELEASE_MS = 200;
  localparam int RELEASE_CYC = RELEASE_MS * 1000 * CLK_MHZ;
  localparam int WDOG_SEL_W = 2;
  localparam int WDOG_W = 32;
  localparam logic [7:0] TRIP_NATIVE = 8'h00;
endpackage

// ==== verilog/supervisor_reset_watchdog.sv ====
/*
  Reset supervisor: power-on/brownout release delay, watchdog on chip
  select, threshold set/restore sequence detection, write-lock freeze.
  Assumes pins are asynchronous and pass a two-flop synchroniser here.
*/
`timescale 1ns/1ps
module supervisor_reset_watchdog #(
  parameter int RELEASE_CYC = supervisor_pkg::RELEASE_CYC,
  parameter bit ACTIVE_HIGH = 1'b0,
  parameter logic [7:0] TRIP_RAISED = 8'h01
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic supplyAboveTrip,
  input wire logic supplyAbove1v,
  input wire logic csN,
  input wire logic sck,
  input wire logic sckProg,
  input wire logic siProg,
  input wire logic wpN,
  input wire logic lockEnableBit,
  input wire logic wdogEnable,
  input wire logic [31:0] wdogLimit,
  output logic resetOut,
  output logic resetOe,
  output logic [7:0] tripCode,
  output logic wdogFrozen
);
  ////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic [6:0] s1_reg;
  logic [6:0] s2_reg;
  logic csPrev_reg;
  logic [6:0] pinsRaw;
  assign pinsRaw = {supplyAboveTrip, supplyAbove1v, csN, sck, sckProg,
                    siProg, wpN};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // Chip select and write-lock start at their idle high level
      s1_reg <= 7'h11;
      s2_reg <= 7'h11;
      csPrev_reg <= 1'b1;
    end else begin
      s1_reg <= pinsRaw;
      s2_reg <= s1_reg;
      csPrev_reg <= s2_reg[4];
    end
  end

  logic aboveTrip;
  logic above1v;
  logic csS;
  logic sckS;
  logic sckPS;
  logic siPS;
  logic wpS;
  assign {aboveTrip, above1v, csS, sckS, sckPS, siPS, wpS} = s2_reg;
  logic csFall;
  logic csRise;
  assign csFall = csPrev_reg & ~csS;
  assign csRise = ~csPrev_reg & csS;

  ////////////////////////////////////////////////////////////////////////
  // Supply release delay
  logic [31:0] delay_reg;
  logic [31:0] delay_next;
  logic inReset_reg;
  logic inReset_next;
  logic wdTrip;

  always_comb begin
    delay_next = delay_reg;
    inReset_next = inReset_reg;
    if (!aboveTrip || !above1v) begin
      delay_next = '0;
      inReset_next = 1'b1;
    end else if (wdTrip) begin
      delay_next = '0;
      inReset_next = 1'b1;
    end else if (inReset_reg) begin
      if (delay_reg >= RELEASE_CYC - 1) begin
        inReset_next = 1'b0;
      end else begin
        delay_next = delay_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      delay_reg <= '0;
      inReset_reg <= 1'b1;
    end else begin
      delay_reg <= delay_next;
      inReset_reg <= inReset_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog
  logic frozenCfg_reg;
  logic frozenCfg_next;
  logic wdEn_reg;
  logic wdEn_next;
  logic [31:0] wdLim_reg;
  logic [31:0] wdLim_next;

  always_comb begin
    frozenCfg_next = lockEnableBit & ~wpS;
    wdEn_next = wdEn_reg;
    wdLim_next = wdLim_reg;
    if (!frozenCfg_reg) begin
      wdEn_next = wdogEnable;
      wdLim_next = wdogLimit;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frozenCfg_reg <= 1'b0;
      wdEn_reg <= 1'b0;
      wdLim_reg <= 32'hFFFFFFFF;
    end else begin
      frozenCfg_reg <= frozenCfg_next;
      wdEn_reg <= wdEn_next;
      wdLim_reg <= wdLim_next;
    end
  end

  wdog_if wd ();
  assign wd.restart = csFall;
  assign wd.hold = inReset_reg | ~wdEn_reg;
  assign wd.limit = wdLim_reg;
  assign wdTrip = wd.expired & wdEn_reg;

  watchdog_counter u_wdog (
    .clk(clk),
    .arst_n(arst_n),
    .wd(wd)
  );

  ////////////////////////////////////////////////////////////////////////
  // Threshold programming sequences
  typedef enum logic [1:0] {PIdle, PLow} prog_t;
  prog_t pst_reg;
  prog_t pst_next;
  logic isSet_reg;
  logic isSet_next;
  logic [7:0] trip_reg;
  logic [7:0] trip_next;
  logic setCond;
  logic rstCond;
  assign setCond = wpS & sckPS & siPS;
  assign rstCond = wpS & sckS & ~sckPS & siPS;

  always_comb begin
    pst_next = pst_reg;
    isSet_next = isSet_reg;
    trip_next = trip_reg;
    unique case (pst_reg)
      PIdle: begin
        if (csFall && (setCond || rstCond)) begin
          pst_next = PLow;
          isSet_next = setCond;
        end
      end
      PLow: begin
        if (!(setCond || rstCond)) begin
          pst_next = PIdle;
        end else if (csRise) begin
          pst_next = PIdle;
          if (isSet_reg) begin
            // Set only raises the stored level
            if (TRIP_RAISED > trip_reg) begin
              trip_next = TRIP_RAISED;
            end
          end else begin
            trip_next = supervisor_pkg::TRIP_NATIVE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pst_reg <= PIdle;
      isSet_reg <= 1'b0;
      trip_reg <= supervisor_pkg::TRIP_NATIVE;
    end else begin
      pst_reg <= pst_next;
      isSet_reg <= isSet_next;
      trip_reg <= trip_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs: open drain drives only the active level
  logic resOe_reg;
  logic resOut_reg;
  logic frozOut_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resOe_reg <= 1'b1;
      resOut_reg <= ACTIVE_HIGH;
      frozOut_reg <= 1'b0;
    end else begin
      resOe_reg <= inReset_next;
      resOut_reg <= ACTIVE_HIGH;
      frozOut_reg <= frozenCfg_reg;
    end
  end
  assign resetOe = resOe_reg;
  assign resetOut = resOut_reg;
  assign tripCode = trip_reg;
  assign wdogFrozen = frozOut_reg;
endmodule

// ==== verilog/watchdog_counter.sv ====
/*
  Watchdog counter: counts cycles since last restart, flags expiry.
  Assumes restart and hold are synchronous to clk.
*/
`timescale 1ns/1ps
module watchdog_counter (
  input wire logic clk,
  input wire logic arst_n,
  wdog_if.cnt wd
);
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic expired_reg;
  logic expired_next;

  always_comb begin
    count_next = count_reg;
    expired_next = 1'b0;
    if (wd.hold || wd.restart) begin
      count_next = '0;
    end else if (count_reg >= wd.limit) begin
      expired_next = 1'b1;
    end else begin
      count_next = count_reg + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= '0;
      expired_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      expired_reg <= expired_next;
    end
  end

  assign wd.expired = expired_reg;
endmodule

// ==== verilog/wdog_if.sv ====
/*
  Signals between the supervisor and its watchdog counter.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface wdog_if;
  logic restart;
  logic hold;
  logic [31:0] limit;
  logic expired;
  modport ctrl (output restart, output hold, output limit, input expired);
  modport cnt (input restart, input hold, input limit, output expired);
endinterface
